// file: verilog/cff_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cff_consts.svh"

// How it works
// - Warn when overall limit below warning level
// - Add command-slope sign times friction value
// - Friction only in velocity or position mode
// - Friction value 0 to min(limit, peak)
// - Drive and motor estimators run side by side
// - Overall limit is min of both estimates
// - Lower foldback limit replaces applied limit
// - Drive estimate not clamped to peak currents
// - Overall limit read-only, 0 to 2147483.647 A
// - Read-only u current, clamped to drive peak
// - Below fault level: fault, drive disabled
// - Fault level is min of three values
module cff_top
  import cff_pkg::*;
#(
  parameter int unsigned LOOP_CYCLES = `CFF_LOOP_CYCLES,
  parameter int unsigned DRIVE_SHIFT = 4,
  parameter int unsigned MOTOR_SHIFT = 6
) (
  input wire logic clock_i,
  input wire logic reset_i,
  // Parameter access port
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_ack_o,
  output logic reg_err_o,
  // Configuration levels, mA
  input wire logic [31:0] foldback_warn_level_i,
  input wire logic [31:0] user_fault_level_i,
  input wire logic [31:0] user_positive_current_limit_i,
  input wire logic [31:0] motor_peak_current_i,
  input wire logic [31:0] drive_peak_current_i,
  input wire logic [1:0] operating_mode_select_i,
  // Estimator parameter sets
  input wire logic [31:0] drive_cont_current_i,
  input wire logic [31:0] drive_fold_ceiling_i,
  input wire logic [31:0] motor_cont_current_i,
  input wire logic [31:0] motor_fold_ceiling_i,
  // Current loop side
  input wire logic signed [31:0] pos_cmd_deriv_i,
  input wire logic signed [31:0] current_cmd_i,
  input wire logic signed [31:0] u_current_meas_i,
  input wire logic drive_enable_req_i,
  input wire logic fault_clear_i,
  output logic signed [31:0] current_cmd_o,
  output logic [31:0] active_current_limit_o,
  output logic [31:0] drive_fold_limit_o,
  output logic [31:0] motor_fold_limit_o,
  output logic foldback_warn_o,
  output logic foldback_fault_o,
  output logic fault_event_o,
  output logic drive_enable_o,
  output logic loop_tick_o
);

  localparam logic [31:0] LoopLast = 32'(LOOP_CYCLES - 1);

  initial begin
    if (LOOP_CYCLES < 2) begin
      $error("cff_top: LOOP_CYCLES must be at least 2");
    end
    if (DRIVE_SHIFT > 31 || MOTOR_SHIFT > 31) begin
      $error("cff_top: estimator shifts must be below 32");
    end
  end

  // Smaller of two unsigned currents, used for the overall, fault, active and friction limits
  function automatic logic [31:0] cff_min(input logic [31:0] a, input logic [31:0] b);
    cff_min = (a < b) ? a : b;
  endfunction : cff_min

  // Saturating signed add, keeps the command from wrapping
  function automatic logic signed [31:0] cff_sat_add(input logic signed [31:0] a,
                                                     input logic signed [31:0] b);
    logic signed [32:0] sum;
    sum = 33'(a) + 33'(b);
    if (sum > 33'sh0_7FFF_FFFF) begin
      cff_sat_add = 32'sh7FFF_FFFF;
    end else if (sum < -33'sh0_8000_0000) begin
      cff_sat_add = 32'sh8000_0000;
    end else begin
      cff_sat_add = sum[31:0];
    end
  endfunction : cff_sat_add

  logic [31:0] loop_count;
  logic loop_tick;
  logic [31:0] friction_comp_value;
  logic [31:0] overall_foldback_limit;
  logic [31:0] u_winding_current;
  logic [31:0] drive_fold_limit;
  logic [31:0] motor_fold_limit;
  logic [31:0] load_mag;
  logic [31:0] next_overall;
  logic [31:0] fault_level;
  logic [31:0] friction_ceiling;
  logic [31:0] friction_wr;
  logic signed [31:0] friction_term;
  logic signed [31:0] next_u_current;
  logic friction_enable;
  logic next_fault;
  logic addr_known;

  // Loop-rate enable; one pulse per current-loop update
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      loop_count <= 32'h0000_0000;
      loop_tick <= 1'b0;
    end else begin
      loop_tick <= (loop_count == LoopLast);
      loop_count <= (loop_count == LoopLast) ? 32'h0000_0000 : loop_count + 32'h0000_0001;
    end
  end

  // Estimators load on the measured phase magnitude
  always_comb begin
    load_mag = u_current_meas_i[31] ? 32'(-u_current_meas_i) : u_current_meas_i;
  end

  // Both estimators share one update tick
  cff_estimator #(
    .DECAY_SHIFT(DRIVE_SHIFT)
  ) u_drive_est (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .tick_i(loop_tick),
    .load_i(load_mag),
    .cont_i(drive_cont_current_i),
    .ceiling_i(drive_fold_ceiling_i),
    .limit_o(drive_fold_limit)
  );

  cff_estimator #(
    .DECAY_SHIFT(MOTOR_SHIFT)
  ) u_motor_est (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .tick_i(loop_tick),
    .load_i(load_mag),
    .cont_i(motor_cont_current_i),
    .ceiling_i(motor_fold_ceiling_i),
    .limit_o(motor_fold_limit)
  );

  // Drive estimate taken as is; peak currents never trim it
  always_comb begin
    next_overall = cff_min(drive_fold_limit, motor_fold_limit);
    if (next_overall > `CFF_FOLD_MAX) begin
      next_overall = `CFF_FOLD_MAX;
    end
  end

  // Effective fault level from three sources
  always_comb begin
    fault_level = cff_min(cff_min(drive_peak_current_i, motor_peak_current_i),
                          user_fault_level_i);
  end

  // Overall limit and the two estimate outputs, refreshed each loop update
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      overall_foldback_limit <= `CFF_RST_OVERALL_FOLD;
      drive_fold_limit_o <= `CFF_RST_OVERALL_FOLD;
      motor_fold_limit_o <= `CFF_RST_OVERALL_FOLD;
    end else if (loop_tick) begin
      overall_foldback_limit <= next_overall;
      drive_fold_limit_o <= drive_fold_limit;
      motor_fold_limit_o <= motor_fold_limit;
    end
  end

  // Active limit; the user limit stands until foldback drops below it
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      active_current_limit_o <= 32'h0000_0000;
    end else if (loop_tick) begin
      active_current_limit_o <= cff_min(next_overall, user_positive_current_limit_i);
    end
  end

  // Warning follows the level, no latching, the host owns the level
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      foldback_warn_o <= 1'b0;
    end else if (loop_tick) begin
      foldback_warn_o <= (next_overall < foldback_warn_level_i);
    end
  end

  // Fault is sticky; a new trip beats a clear in the same cycle
  always_comb begin
    next_fault = loop_tick && (next_overall < fault_level);
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      foldback_fault_o <= 1'b0;
      fault_event_o <= 1'b0;
    end else begin
      fault_event_o <= next_fault && !foldback_fault_o;
      if (next_fault) begin
        foldback_fault_o <= 1'b1;
      end else if (fault_clear_i) begin
        foldback_fault_o <= 1'b0;
      end
    end
  end

  // Output stage cut off at the same edge the fault latches
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      drive_enable_o <= 1'b0;
    end else begin
      drive_enable_o <= drive_enable_req_i && !foldback_fault_o && !next_fault;
    end
  end

  // Friction only where a position command slope means motion intent
  always_comb begin
    friction_enable = (operating_mode_select_i == CFF_MODE_VELOCITY) ||
                      (operating_mode_select_i == CFF_MODE_POSITION);
    if (!friction_enable || pos_cmd_deriv_i == 32'sh0000_0000) begin
      friction_term = 32'sh0000_0000;
    end else if (pos_cmd_deriv_i[31]) begin
      friction_term = -$signed(friction_comp_value);
    end else begin
      friction_term = $signed(friction_comp_value);
    end
  end

  // Command out with friction injected, once per loop update
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      current_cmd_o <= 32'sh0000_0000;
    end else if (loop_tick) begin
      current_cmd_o <= cff_sat_add(current_cmd_i, friction_term);
    end
  end

  // Reported u current limited to the drive peak either way
  always_comb begin
    next_u_current = u_current_meas_i;
    if (load_mag > drive_peak_current_i) begin
      next_u_current = u_current_meas_i[31] ? -$signed(drive_peak_current_i)
                                            : $signed(drive_peak_current_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      u_winding_current <= `CFF_RST_U_WINDING;
    end else if (loop_tick) begin
      u_winding_current <= next_u_current;
    end
  end

  // Writes above the ceiling are clamped, not refused
  always_comb begin
    friction_ceiling = cff_min(user_positive_current_limit_i, motor_peak_current_i);
    friction_wr = cff_min(reg_wdata_i, friction_ceiling);
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      friction_comp_value <= `CFF_RST_FRICTION_COMP;
    end else if (reg_wr_i && reg_addr_i == `CFF_OFF_FRICTION_COMP) begin
      friction_comp_value <= friction_wr;
    end else if (friction_comp_value > friction_ceiling) begin
      // Ceiling may drop after the write; keep the value legal
      friction_comp_value <= friction_ceiling;
    end
  end

  always_comb begin
    addr_known = (reg_addr_i == `CFF_OFF_FRICTION_COMP) ||
                 (reg_addr_i == `CFF_OFF_OVERALL_FOLD) ||
                 (reg_addr_i == `CFF_OFF_U_WINDING);
  end

  // Access answer one cycle later; read-only targets reject writes
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h0000_0000;
      reg_ack_o <= 1'b0;
      reg_err_o <= 1'b0;
    end else begin
      reg_ack_o <= reg_wr_i || reg_rd_i;
      reg_err_o <= (reg_wr_i || reg_rd_i) &&
                   (!addr_known || (reg_wr_i && reg_addr_i != `CFF_OFF_FRICTION_COMP));
      if (reg_rd_i) begin
        case (reg_addr_i)
          `CFF_OFF_FRICTION_COMP: reg_rdata_o <= friction_comp_value;
          `CFF_OFF_OVERALL_FOLD: reg_rdata_o <= overall_foldback_limit;
          `CFF_OFF_U_WINDING: reg_rdata_o <= u_winding_current;
          default: reg_rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Loop tick exported so the loop can latch the new command
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      loop_tick_o <= 1'b0;
    end else begin
      loop_tick_o <= loop_tick;
    end
  end

endmodule : cff_top

`default_nettype wire

// file: verilog/cff_consts.svh
`ifndef CFF_CONSTS_SVH
`define CFF_CONSTS_SVH

// Parameter access offsets
`define CFF_OFF_FRICTION_COMP 16'h01BA
`define CFF_OFF_OVERALL_FOLD 16'h01BC
`define CFF_OFF_U_WINDING 16'h01BE

// Reset values
`define CFF_RST_FRICTION_COMP 32'h0000_0000
`define CFF_RST_OVERALL_FOLD 32'h0000_0000
`define CFF_RST_U_WINDING 32'h0000_0000
`define CFF_RST_ESTIMATE 32'h7FFF_FFFF

// Largest overall limit, 2147483.647 A in mA steps
`define CFF_FOLD_MAX 32'h7FFF_FFFF

// Current-loop update timing
`define CFF_CLOCK_PERIOD_NS 10
`define CFF_LOOP_PERIOD_NS 16000
`define CFF_LOOP_CYCLES (`CFF_LOOP_PERIOD_NS / `CFF_CLOCK_PERIOD_NS)

`endif

// file: verilog/cff_pkg.sv
package cff_pkg;

  // Operating mode codes as seen on the mode select input
  typedef enum logic [1:0] {
    CFF_MODE_TORQUE   = 2'b00,
    CFF_MODE_VELOCITY = 2'b01,
    CFF_MODE_POSITION = 2'b10,
    CFF_MODE_SPARE    = 2'b11
  } cff_opmode_e;

  // Currents in mA, unsigned magnitudes
  typedef logic [31:0] cff_current_t;

endpackage : cff_pkg

// file: verilog/cff_estimator.sv
`timescale 1ns/1ps
`default_nettype none

module cff_estimator
  import cff_pkg::*;
#(
  parameter int unsigned DECAY_SHIFT = 4
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic tick_i,
  input wire logic [31:0] load_i,
  input wire logic [31:0] cont_i,
  input wire logic [31:0] ceiling_i,
  output logic [31:0] limit_o
);

  `include "cff_consts.svh"

  initial begin
    if (DECAY_SHIFT > 31) begin
      $error("cff_estimator: DECAY_SHIFT must be below 32");
    end
  end

  logic [31:0] delta;
  logic [32:0] rise;
  logic [31:0] next_limit;

  // Above continuous the limit drains, below it refills toward the ceiling
  always_comb begin
    delta = 32'h0000_0000;
    rise = 33'h0_0000_0000;
    next_limit = limit_o;
    if (load_i > cont_i) begin
      delta = (load_i - cont_i) >> DECAY_SHIFT;
      next_limit = (limit_o > delta) ? (limit_o - delta) : 32'h0000_0000;
    end else begin
      delta = (cont_i - load_i) >> DECAY_SHIFT;
      rise = {1'b0, limit_o} + {1'b0, delta};
      next_limit = (rise > {1'b0, ceiling_i}) ? ceiling_i : rise[31:0];
    end
    // Ceiling is its own figure, not a peak current
    if (next_limit > ceiling_i) begin
      next_limit = ceiling_i;
    end
  end

  // Updated once per current-loop cycle
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      limit_o <= `CFF_RST_ESTIMATE;
    end else if (tick_i) begin
      limit_o <= next_limit;
    end
  end

endmodule : cff_estimator

`default_nettype wire

// file: bench/cff_chk.sv
`timescale 1ns/1ps
`default_nettype none

module cff_chk #(
  parameter int unsigned LOOP_CYCLES = 4
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_ack_o,
  input wire logic reg_err_o,
  input wire logic [31:0] foldback_warn_level_i,
  input wire logic [31:0] user_fault_level_i,
  input wire logic [31:0] user_positive_current_limit_i,
  input wire logic [31:0] motor_peak_current_i,
  input wire logic [31:0] drive_peak_current_i,
  input wire logic [1:0] operating_mode_select_i,
  input wire logic signed [31:0] pos_cmd_deriv_i,
  input wire logic signed [31:0] current_cmd_i,
  input wire logic signed [31:0] current_cmd_o,
  input wire logic [31:0] active_current_limit_o,
  input wire logic foldback_warn_o,
  input wire logic foldback_fault_o,
  input wire logic fault_event_o,
  input wire logic drive_enable_o,
  input wire logic loop_tick_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic rd_fold;
  logic rd_u;
  logic seen;
  logic [31:0] pk;
  logic [31:0] lvl;
  int unsigned gap;
  // Effective fault level, lowest of three
  assign pk = (drive_peak_current_i < motor_peak_current_i) ? drive_peak_current_i : motor_peak_current_i;
  assign lvl = (pk < user_fault_level_i) ? pk : user_fault_level_i;
  // Which value the next ack answers
  always_ff @(posedge clock_i) begin
    rd_fold <= reg_rd_i && !reg_wr_i && (reg_addr_i == 16'h01BC);
    rd_u <= reg_rd_i && !reg_wr_i && (reg_addr_i == 16'h01BE);
  end
  // Cycles since the last tick
  always_ff @(posedge clock_i) begin
    if (reset_i || loop_tick_o) begin
      gap <= 0;
    end else begin
      gap <= gap + 1;
    end
  end
  // First tick after reset has its own offset, so skip it
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      seen <= 1'b0;
    end else if (loop_tick_o) begin
      seen <= 1'b1;
    end
  end
  ro_write_err_a: assert property (
    reg_wr_i && (reg_addr_i == 16'h01BC || reg_addr_i == 16'h01BE) |=> reg_ack_o && reg_err_o)
    else $error("write to read-only value not refused");
  warn_level_a: assert property (
    reg_ack_o && rd_fold && !loop_tick_o && $stable(foldback_warn_level_i)
    |-> foldback_warn_o == (reg_rdata_o < foldback_warn_level_i)) else $error("warning flag wrong");
  fault_trip_a: assert property (
    reg_ack_o && rd_fold && !loop_tick_o && $stable(lvl) && reg_rdata_o < lvl |-> foldback_fault_o)
    else $error("fault missing below fault level");
  fold_active_a: assert property (
    reg_ack_o && rd_fold && !loop_tick_o |-> active_current_limit_o <= reg_rdata_o)
    else $error("active limit above foldback limit");
  user_active_a: assert property (
    loop_tick_o |-> active_current_limit_o <= $past(user_positive_current_limit_i))
    else $error("active limit above user limit");
  fault_disable_a: assert property (
    foldback_fault_o |-> !drive_enable_o) else $error("drive enabled while fault set");
  fault_event_a: assert property (
    $rose(foldback_fault_o) |-> fault_event_o ##1 !fault_event_o) else $error("fault event pulse wrong");
  no_friction_a: assert property (
    loop_tick_o && ($past(operating_mode_select_i) inside {2'h0, 2'h3} || $past(pos_cmd_deriv_i) == 0)
    |-> current_cmd_o == $past(current_cmd_i)) else $error("friction injected when off");
  tick_spacing_a: assert property (
    loop_tick_o && seen |-> gap == LOOP_CYCLES - 1) else $error("loop update spacing wrong");
  hold_between_a: assert property (
    $changed(active_current_limit_o) || $changed(current_cmd_o) |-> loop_tick_o)
    else $error("loop output moved between updates");
  u_clamp_a: assert property (
    reg_ack_o && rd_u |-> $signed(reg_rdata_o) <= $signed(drive_peak_current_i)
    && $signed(reg_rdata_o) >= -$signed(drive_peak_current_i)) else $error("u current beyond peak");
endmodule : cff_chk

bind cff_top cff_chk #(.LOOP_CYCLES(LOOP_CYCLES)) i_chk (
  .clock_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_ack_o, .reg_err_o,
  .foldback_warn_level_i, .user_fault_level_i, .user_positive_current_limit_i, .motor_peak_current_i,
  .drive_peak_current_i, .operating_mode_select_i, .pos_cmd_deriv_i, .current_cmd_i, .current_cmd_o,
  .active_current_limit_o, .foldback_warn_o, .foldback_fault_o, .fault_event_o, .drive_enable_o, .loop_tick_o
);

`default_nettype wire

// file: bench/cff_host.sv
`timescale 1ns/1ps
`default_nettype none

module cff_host (
  input wire logic clock_i,
  input wire logic [31:0] rdata_i,
  input wire logic ack_i,
  input wire logic err_i,
  output logic [15:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [31:0] wdata_o
);
  // Idle bus, no strobe
  initial begin
    addr_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 32'h0000_0000;
  end
  // One-cycle strobe, answer taken with the ack a cycle later
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic k);
    @(negedge clock_i);
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(negedge clock_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = ~d; // Stale data must not look valid
    q = rdata_i;
    e = err_i;
    k = ack_i;
  endtask : xfer
endmodule : cff_host

`default_nettype wire

// file: bench/cff_tb.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import cff_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] reg_addr_i;
  logic reg_wr_i, reg_rd_i, reg_ack_o, reg_err_o, e;
  logic [31:0] reg_wdata_i, reg_rdata_o, q, x;
  logic [31:0] foldback_warn_level_i = 32'h0;
  logic [31:0] user_fault_level_i = 32'h0, user_positive_current_limit_i = 32'h2710;
  logic [31:0] motor_peak_current_i = 32'h2710, drive_peak_current_i = 32'h0FA0;
  logic [31:0] drive_cont_current_i = 32'h0010_0000, drive_fold_ceiling_i = 32'h1388;
  logic [31:0] motor_cont_current_i = 32'h0010_0000, motor_fold_ceiling_i = 32'h0BB8;
  logic [1:0] operating_mode_select_i = 2'h0;
  logic signed [31:0] pos_cmd_deriv_i = 32'h0, current_cmd_i = 32'h0, u_current_meas_i = 32'h0;
  logic drive_enable_req_i = 1'b1, fault_clear_i = 1'b0;
  logic signed [31:0] current_cmd_o;
  logic [31:0] active_current_limit_o, drive_fold_limit_o, motor_fold_limit_o;
  logic foldback_warn_o, foldback_fault_o, fault_event_o, drive_enable_o, loop_tick_o;
  int errors = 0;
  int check_count = 0;
  // Rows: warn, user fault, user limit, motor peak, drive peak
  logic [159:0] lv [5] = '{{32'h0BB8, 32'h07D0, 32'h2710, 32'h2710, 32'h0FA0},
    {32'h0BB9, 32'h07D0, 32'h07D0, 32'h2710, 32'h0FA0}, {32'h0, 32'h0BB9, 32'h2710, 32'h2710, 32'h0FA0},
    {32'h0, 32'h2710, 32'h2710, 32'h0BB9, 32'h0FA0}, {32'h0, 32'h2710, 32'h2710, 32'h2710, 32'h0BB9}};
  logic [31:0] lx [5] = '{32'h0BB8, 32'h07D0, 32'h0BB8, 32'h0BB8, 32'h0BB8};
  logic [1:0] lf [5] = '{2'h0, 2'h2, 2'h1, 2'h1, 2'h1};
  // Rows: mode, slope, command expected with friction 1000 on 5000
  logic [65:0] cr [5] = '{{2'h1, 32'h5, 32'h1770}, {2'h2, 32'hFFFF_FFFB, 32'h0FA0},
    {2'h0, 32'h5, 32'h1388}, {2'h3, 32'h5, 32'h1388}, {2'h1, 32'h0, 32'h1388}};
  logic [16:0] rf [4] = '{{1'b1, 16'h01BC}, {1'b1, 16'h01BE}, {1'b0, 16'h0000}, {1'b1, 16'h01B8}};

  cff_top #(.LOOP_CYCLES(4)) i_dut (
    .clock_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o,
    .reg_err_o, .foldback_warn_level_i, .user_fault_level_i, .user_positive_current_limit_i,
    .motor_peak_current_i, .drive_peak_current_i, .operating_mode_select_i, .drive_cont_current_i,
    .drive_fold_ceiling_i, .motor_cont_current_i, .motor_fold_ceiling_i, .pos_cmd_deriv_i, .current_cmd_i,
    .u_current_meas_i, .drive_enable_req_i, .fault_clear_i, .current_cmd_o, .active_current_limit_o,
    .drive_fold_limit_o, .motor_fold_limit_o, .foldback_warn_o, .foldback_fault_o, .fault_event_o,
    .drive_enable_o, .loop_tick_o
  );
  cff_host i_host (.clock_i, .rdata_i(reg_rdata_o), .ack_i(reg_ack_o), .err_i(reg_err_o),
    .addr_o(reg_addr_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i), .wdata_o(reg_wdata_i));

  always #5 clock_i = ~clock_i;

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] w);
    check_count++;
    if (s !== w) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, w, s);
    end
  endtask : chk
  // Every access must be answered one cycle later
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    logic k;
    i_host.xfer(w, a, d, q, e, k);
    chk("ack", {31'h0, k}, 32'h1);
  endtask : acc
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock_i);
    errors++;
    give_verdict();
  end

  initial begin
    repeat (4) @(negedge clock_i);
    reset_i = 1'b0;
    // Level table; a clear with fault level 0 comes first
    for (int i = 0; i < 5; i++) begin
      user_fault_level_i = 32'h0;
      fault_clear_i = 1'b1;
      repeat (12) @(negedge clock_i);
      fault_clear_i = 1'b0;
      {foldback_warn_level_i, user_fault_level_i, user_positive_current_limit_i, motor_peak_current_i,
        drive_peak_current_i} = lv[i];
      repeat (40) @(negedge clock_i);
      chk("active", active_current_limit_o, lx[i]);
      chk("flags", {30'h0, foldback_warn_o, foldback_fault_o}, {30'h0, lf[i]});
      chk("enable", {31'h0, drive_enable_o}, {31'h0, !lf[i][0]});
      chk("drive_fold", drive_fold_limit_o, 32'h1388);
      chk("motor_fold", motor_fold_limit_o, 32'h0BB8);
      acc(1'b0, 16'h01BC, 32'h0);
      chk("overall", q, 32'h0BB8);
    end
    $display("test levels done");
    // Friction range, clamp and later pull-down
    {foldback_warn_level_i, user_fault_level_i, drive_peak_current_i} = {32'h0, 32'h0, 32'h0FA0};
    user_positive_current_limit_i = 32'h07D0;
    fault_clear_i = 1'b1;
    repeat (12) @(negedge clock_i);
    fault_clear_i = 1'b0;
    acc(1'b1, 16'h01BA, 32'h64);
    acc(1'b0, 16'h01BA, 32'h0);
    chk("friction", q, 32'h64);
    acc(1'b1, 16'h01BA, 32'hFFFF);
    acc(1'b0, 16'h01BA, 32'h0);
    chk("friction_clamp", q, 32'h07D0);
    user_positive_current_limit_i = 32'h03E8;
    repeat (12) @(negedge clock_i);
    acc(1'b0, 16'h01BA, 32'h0);
    chk("friction_pull", q, 32'h03E8);
    current_cmd_i = 32'h1388;
    for (int i = 0; i < 5; i++) begin
      {operating_mode_select_i, pos_cmd_deriv_i, x} = cr[i];
      repeat (12) @(negedge clock_i);
      chk("command", current_cmd_o, x);
    end
    $display("test friction done");
    // Measured u current, inside and beyond the drive peak
    u_current_meas_i = 32'h64;
    repeat (12) @(negedge clock_i);
    acc(1'b0, 16'h01BE, 32'h0);
    chk("u_current", q, 32'h64);
    u_current_meas_i = 32'hFFFF_E4A8;
    repeat (12) @(negedge clock_i);
    acc(1'b0, 16'h01BE, 32'h0);
    chk("u_clamp", q, 32'hFFFF_F060);
    $display("test u current done");
    // Read-only and unmapped places refuse, friction untouched
    for (int i = 0; i < 4; i++) begin
      acc(rf[i][16], rf[i][15:0], 32'h55);
      chk("refused", {31'h0, e}, 32'h1);
    end
    acc(1'b0, 16'h01BA, 32'h0);
    chk("friction_kept", q, 32'h03E8);
    $display("test refusal done");
    // Reset in mid-run restores the friction default
    reset_i = 1'b1;
    repeat (4) @(negedge clock_i);
    reset_i = 1'b0;
    acc(1'b0, 16'h01BA, 32'h0);
    chk("friction_reset", q, 32'h0);
    chk("fault_reset", {31'h0, foldback_fault_o}, 32'h0);
    chk("active_reset", active_current_limit_o, 32'h0);
    $display("test reset done");
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
